// ==== dv/dswp_display_model.sv ====
// dswp_display_model: behavioural display controller on the 4-wire write port.
// assumes mode zero traffic; answers every byte with i_reply, msb first.
`timescale 1ns/10ps
`default_nettype none

module dswp_display_model (
    // display pins
    input  wire logic       i_select_low,
    input  wire logic       i_cmd_data,
    input  wire logic       i_sclk,
    input  wire logic       i_sdata,
    input  wire logic       i_backlight,
    output logic            o_read_line,
    // reply pattern
    input  wire logic [7:0] i_reply
);
    int          rx_q[$];
    int          errs;
    int          nbits;
    int          txbit;
    int          addr;
    logic        half;
    logic        lit;
    logic [7:0]  shift;
    logic [15:0] colour;
    logic [17:0] frame_mem [0:153599];

    assign lit = i_backlight;
    initial
    begin
        half = 1'b0;
        o_read_line = 1'b0;
    end
    always @(negedge i_select_low)
    begin
        if (i_sclk)
            errs++;
        nbits = 0;
        txbit = 0;
        o_read_line = i_reply[7];
    end
    // released line: inverse of the last value, so a stale sample shows up
    always @(posedge i_select_low)
        o_read_line = ~o_read_line;
    always @(negedge i_sclk)
        if (!i_select_low)
        begin
            txbit++;
            o_read_line = i_reply[7 - txbit % 8];
        end
    always @(posedge i_sclk)
        if (!i_select_low)
        begin
            shift = {shift[6:0], i_sdata};
            nbits++;
            if (nbits % 8 == 0)
            begin
                rx_q.push_back(int'({i_cmd_data, shift}));
                if (!i_cmd_data)
                begin
                    addr = 0;
                    half = 1'b0;
                end
                else
                begin
                    colour = {colour[7:0], shift};
                    half = ~half;
                    if (!half)
                    begin
                        frame_mem[addr] = {colour[15:11], colour[15], colour[10:5],
                                           colour[4:0], colour[4]};
                        addr = (addr + 1) % 153600;
                    end
                end
            end
        end
endmodule : dswp_display_model

`default_nettype wire

// ==== dv/dswp_host_monitor.sv ====
// dswp_host_monitor: concurrent checks on the display pins and the register port.
// assumes it is bound to dswp_host and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module dswp_host_monitor (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    // software register port
    input wire logic [7:0]  i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic        i_reg_write,
    input wire logic        i_reg_read,
    input wire logic [31:0] o_reg_rdata,
    // display pins
    input wire logic        o_display_select_low,
    input wire logic        o_cmd_data_select,
    input wire logic        o_serial_clock,
    input wire logic        o_serial_write_data,
    input wire logic        o_backlight_enable,
    input wire logic        o_display_reset_n
);
    default clocking mon_cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // rising serial clock edges seen in the current frame
    logic       sck_q;
    logic       sck_d;
    logic [4:0] rises_q;
    logic [4:0] rises_d;
    always_comb
    begin
        sck_d   = o_serial_clock;
        rises_d = o_display_select_low ? 5'h0 : rises_q + {4'h0, o_serial_clock & ~sck_q};
    end
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_q   <= 1'b0;
            rises_q <= 5'h0;
        end
        else
        begin
            sck_q   <= sck_d;
            rises_q <= rises_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_clock_idle_low: assert property (o_display_select_low |-> !o_serial_clock)
        else $error("serial clock high while deselected");
    a_rise_selected: assert property ($rose(o_serial_clock) |-> !o_display_select_low)
        else $error("serial clock rose outside a frame");
    a_bit_held: assert property (o_serial_clock |-> $stable(o_serial_write_data))
        else $error("write data moved while serial clock high");
    a_high_half: assert property ($rose(o_serial_clock) |-> o_serial_clock [*4] ##1 !o_serial_clock)
        else $error("serial clock high phase not four cycles");
    a_low_half: assert property ($fell(o_serial_clock) |-> !o_serial_clock [*4])
        else $error("serial clock low phase too short");
    a_dc_steady: assert property (!o_display_select_low && !$past(o_display_select_low)
        |-> $stable(o_cmd_data_select)) else $error("command/data level moved in a frame");
    a_whole_bytes: assert property ($rose(o_display_select_low)
        |-> rises_q == 5'd8 || rises_q == 5'd16) else $error("frame not whole bytes");
    a_select_rest: assert property ($rose(o_display_select_low) |-> o_display_select_low [*5])
        else $error("select released too briefly");
    a_backlight_write: assert property (i_reg_write && i_reg_addr == dswp_pkg::REG_CONTROL
        |=> o_backlight_enable == $past(i_reg_wdata[0])) else $error("backlight not updated");
    a_reset_pin_write: assert property (i_reg_write && i_reg_addr == dswp_pkg::REG_CONTROL
        |=> o_display_reset_n == !$past(i_reg_wdata[1])) else $error("reset pin not updated");
    a_rdata_idle: assert property (!$past(i_reg_read) |-> o_reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule : dswp_host_monitor

bind dswp_host dswp_host_monitor u_monitor (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata,
    .i_reg_write, .i_reg_read, .o_reg_rdata, .o_display_select_low, .o_cmd_data_select,
    .o_serial_clock, .o_serial_write_data, .o_backlight_enable, .o_display_reset_n);

`default_nettype wire

// ==== dv/dswp_host_tb.sv ====
// dswp_host_tb: self-checking bench for the display serial write port.
// assumes the display model on the far side; expectations kept in a byte queue.
`timescale 1ns/10ps
`default_nettype none

module dswp_host_tb;
    logic        i_clock;
    logic        i_rst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        qready, sel_n, dc, sck, mosi, miso, bl, rst_pin;
    logic [7:0]  reply;
    logic [31:0] s;
    logic [15:0] v;
    int          fails, compares, cycles, seed, k, n;
    int          exp_q[$];

    dswp_host uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata),
        .o_queue_ready(qready), .o_display_select_low(sel_n), .o_cmd_data_select(dc),
        .o_serial_clock(sck), .o_serial_write_data(mosi), .i_serial_read_line(miso),
        .o_backlight_enable(bl), .o_display_reset_n(rst_pin));
    dswp_display_model dev (.i_select_low(sel_n), .i_cmd_data(dc), .i_sclk(sck),
        .i_sdata(mosi), .i_backlight(bl), .o_read_line(miso), .i_reply(reply));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up;
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    // kind 0 command, 1 parameter, 2 pixel; keep=0 for a write that must be dropped
    task automatic send(input int kind, input logic [15:0] val, input bit keep);
        reg_wr(dswp_pkg::REG_COMMAND + 8'(kind * 4), {16'h0, val});
        if (keep && kind == 2)
            exp_q.push_back(int'({1'b1, val[15:8]}));
        if (keep)
            exp_q.push_back(int'({kind != 0, val[7:0]}));
    endtask : send

    task automatic drain;
        n = 0;
        do
        begin
            reg_rd(dswp_pkg::REG_STATUS, s);
            n++;
        end
        while (s[2:0] !== 3'b100 && n < 600);
        chk("byte count", exp_q.size(), dev.rx_q.size());
        while (exp_q.size() > 0 && dev.rx_q.size() > 0)
            chk("byte", exp_q.pop_front(), dev.rx_q.pop_front());
        exp_q.delete();
        dev.rx_q.delete();
    endtask : drain

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            fails++;
            wrap_up();
        end
    end

    initial
    begin
        seed = 32'h43d8;
        {i_rst_n, wr, rd, addr, wdata, reply} = '0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        chk("idle pins", 32'h11, {27'h0, sel_n, dc, sck, bl, rst_pin});
        reg_rd(dswp_pkg::REG_STATUS, s);
        chk("status after reset", 32'h4, s);
        for (k = 0; k < 4; k++)
        begin
            reg_wr(dswp_pkg::REG_CONTROL, 32'(k));
            reg_rd(dswp_pkg::REG_CONTROL, s);
            chk("control", 32'(k), s);
            chk("backlight and reset", {30'h0, bl, rst_pin}, {30'h0, k[0], !k[1]});
        end
        reg_wr(dswp_pkg::REG_CONTROL, 32'h1);
        reg_wr(8'h18, 32'hffffffff);
        reg_rd(8'h18, s);
        chk("unmapped", 32'h0, s);
        reg_rd(dswp_pkg::REG_CONTROL, s);
        chk("control kept", 32'h1, s);
        // random mix of commands, parameters and pixels
        reply = 8'($random(seed));
        for (int j = 0; j < 12; j++)
        begin
            do @(negedge i_clock); while (qready !== 1'b1);
            k = ($random(seed) & 32'h7fffffff) % 3;
            v = 16'($random(seed));
            send(k, v, 1'b1);
        end
        drain();
        reg_rd(dswp_pkg::REG_RXDATA, s);
        chk("read line byte", {24'h0, reply}, s);
        chk("model protocol errors", 32'h0, 32'(dev.errs));
        // one in service, four queued, sixth dropped
        for (int j = 0; j < 6; j++)
            send((j > 0) + (j == 1 || j == 2), v, j < 5);
        reg_rd(dswp_pkg::REG_STATUS, s);
        chk("status full", 32'h4b, s);
        chk("queue ready", 32'h0, {31'h0, qready});
        reg_wr(dswp_pkg::REG_STATUS, 32'h8);
        drain();
        chk("status drained", 32'h4, s);
        chk("pixel", 32'({v[15:11], v[15], v[10:5], v[4:0], v[4]}), 32'(dev.frame_mem[1]));
        wrap_up();
    end
endmodule : dswp_host_tb

`default_nettype wire

// ==== rtl/dswp_divider.sv ====
// dswp_divider: one-cycle enable every HALF cycles while i_run is high.
// assumes i_run low clears the count, so each run starts with a full interval.
`timescale 1ns/10ps
`default_nettype none

module dswp_divider #(
    parameter int HALF = 4
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_run,
    output logic      o_tick
);

    localparam logic [dswp_pkg::DIV_WIDTH-1:0] LAST = dswp_pkg::DIV_WIDTH'(HALF - 1);

    logic [dswp_pkg::DIV_WIDTH-1:0] cnt_q;
    logic [dswp_pkg::DIV_WIDTH-1:0] cnt_d;

    assign o_tick = i_run && (cnt_q == LAST);

    always_comb
    begin
        if (!i_run || o_tick)
        begin
            cnt_d = '0;
        end
        else
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule : dswp_divider

`default_nettype wire

// ==== rtl/dswp_fifo.sv ====
// dswp_fifo: small first-in first-out buffer with valid/ready on both sides.
// assumes DEPTH is a power of two; everything on one clock.
`timescale 1ns/10ps
`default_nettype none

module dswp_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data,
    // fill level
    output logic [$clog2(DEPTH):0] o_count
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rd_q];
    assign o_count = cnt_q;
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_comb
    begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = i_data;
            wr_d        = wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : dswp_fifo

`default_nettype wire

// ==== rtl/dswp_host.sv ====
// dswp_host: serial master that drives a display controller's 4-wire write port.
// assumes software on the same clock; display pins are outside the clock's domain.
`timescale 1ns/10ps
`default_nettype none

module dswp_host (
    // clock and reset
    input  wire logic                              i_clock,
    input  wire logic                              i_rst_n,
    // software register port
    input  wire logic [dswp_pkg::ADDR_WIDTH-1:0]   i_reg_addr,
    input  wire logic [31:0]                       i_reg_wdata,
    input  wire logic                              i_reg_write,
    input  wire logic                              i_reg_read,
    output logic [31:0]                            o_reg_rdata,
    // queue back-pressure
    output logic                                   o_queue_ready,
    // display pins
    output logic                                   o_display_select_low,
    output logic                                   o_cmd_data_select,
    output logic                                   o_serial_clock,
    output logic                                   o_serial_write_data,
    input  wire logic                              i_serial_read_line,
    output logic                                   o_backlight_enable,
    output logic                                   o_display_reset_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int CW = $clog2(dswp_pkg::FIFO_DEPTH) + 1;

    dswp_pkg::dswp_state_e state_q;
    dswp_pkg::dswp_state_e state_d;

    logic [1:0]               ctrl_q;
    logic [1:0]               ctrl_d;
    logic                     overflow_q;
    logic                     overflow_d;
    logic [31:0]              rdata_q;
    logic [31:0]              rdata_d;
    logic [15:0]              tx_shift_q;
    logic [15:0]              tx_shift_d;
    logic [7:0]               rx_shift_q;
    logic [7:0]               rx_shift_d;
    logic [7:0]               rx_data_q;
    logic [7:0]               rx_data_d;
    logic [4:0]               bits_q;
    logic [4:0]               bits_d;
    logic                     select_q;
    logic                     select_d;
    logic                     dc_q;
    logic                     dc_d;
    logic                     sck_q;
    logic                     sck_d;
    logic                     mosi_q;
    logic                     mosi_d;
    logic                     rx_meta_q;
    logic                     rx_sync_q;

    dswp_pkg::dswp_item_s     push_item;
    dswp_pkg::dswp_item_s     head_item;
    logic                     push_valid;
    logic                     fifo_ready;
    logic                     fifo_valid;
    logic                     fifo_pop;
    logic [CW-1:0]            fifo_count;
    logic                     tick;
    logic                     run;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic reg_hit(
        input logic [dswp_pkg::ADDR_WIDTH-1:0] addr,
        input logic [dswp_pkg::ADDR_WIDTH-1:0] offset
    );
        reg_hit = (addr == offset);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////////
    // queue of pending transfers; software ordering is kept end to end

    always_comb
    begin
        push_item  = '0;
        push_valid = 1'b0;
        if (i_reg_write)
        begin
            if (reg_hit(i_reg_addr, dswp_pkg::REG_COMMAND))
            begin
                push_valid        = 1'b1;
                push_item.is_data = 1'b0;
                push_item.payload = {i_reg_wdata[7:0], 8'h00};
            end
            else if (reg_hit(i_reg_addr, dswp_pkg::REG_PARAM))
            begin
                push_valid        = 1'b1;
                push_item.is_data = 1'b1;
                push_item.payload = {i_reg_wdata[7:0], 8'h00};
            end
            else if (reg_hit(i_reg_addr, dswp_pkg::REG_PIXEL))
            begin
                push_valid         = 1'b1;
                push_item.is_data  = 1'b1;
                push_item.is_pixel = 1'b1;
                push_item.payload  = i_reg_wdata[15:0];
            end
        end
    end

    // window commands and colours leave in the order written
    dswp_fifo #(
        .WIDTH (dswp_pkg::ITEM_WIDTH),
        .DEPTH (dswp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_valid (push_valid),
        .o_ready (fifo_ready),
        .i_data  (push_item),
        .o_valid (fifo_valid),
        .i_ready (fifo_pop),
        .o_data  (head_item),
        .o_count (fifo_count)
    );

    assign o_queue_ready = fifo_ready;

    ////////////////////////////////////////////////////////////////////////////////
    // serial clock pacing: one tick per half period

    assign run = (state_q != dswp_pkg::ST_IDLE);

    dswp_divider #(
        .HALF (dswp_pkg::SCK_HALF_CYCLES)
    ) u_divider (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_run   (run),
        .o_tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read line synchroniser; the pin may be left open

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_meta_q <= 1'b0;
            rx_sync_q <= 1'b0;
        end
        else
        begin
            rx_meta_q <= i_serial_read_line;
            rx_sync_q <= rx_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer engine

    always_comb
    begin
        state_d    = state_q;
        tx_shift_d = tx_shift_q;
        rx_shift_d = rx_shift_q;
        rx_data_d  = rx_data_q;
        bits_d     = bits_q;
        select_d   = select_q;
        dc_d       = dc_q;
        sck_d      = sck_q;
        mosi_d     = mosi_q;
        fifo_pop   = 1'b0;
        case (state_q)
            dswp_pkg::ST_IDLE:
            begin
                sck_d    = 1'b0;
                select_d = 1'b1;
                if (fifo_valid)
                begin
                    fifo_pop   = 1'b1;
                    select_d   = 1'b0;
                    dc_d       = head_item.is_data;
                    tx_shift_d = head_item.payload;
                    mosi_d     = head_item.payload[15];
                    if (head_item.is_pixel)
                    begin
                        bits_d = 5'(dswp_pkg::PIXEL_BITS);
                    end
                    else
                    begin
                        bits_d = 5'(dswp_pkg::BYTE_BITS);
                    end
                    state_d = dswp_pkg::ST_LEAD;
                end
            end
            dswp_pkg::ST_LEAD,
            dswp_pkg::ST_LOW:
            begin
                if (tick)
                begin
                    sck_d      = 1'b1;
                    rx_shift_d = {rx_shift_q[6:0], rx_sync_q};
                    state_d    = dswp_pkg::ST_HIGH;
                end
            end
            dswp_pkg::ST_HIGH:
            begin
                if (tick)
                begin
                    sck_d  = 1'b0;
                    bits_d = bits_q - 5'h01;
                    if (bits_q == 5'h01)
                    begin
                        rx_data_d = rx_shift_q;
                        state_d   = dswp_pkg::ST_TAIL;
                    end
                    else
                    begin
                        tx_shift_d = {tx_shift_q[14:0], 1'b0};
                        mosi_d     = tx_shift_q[14];
                        state_d    = dswp_pkg::ST_LOW;
                    end
                end
            end
            dswp_pkg::ST_TAIL:
            begin
                // select stays low a half period past the last falling edge
                if (tick)
                begin
                    select_d = 1'b1;
                    state_d  = dswp_pkg::ST_REST;
                end
            end
            dswp_pkg::ST_REST:
            begin
                if (tick)
                begin
                    state_d = dswp_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_d  = dswp_pkg::ST_IDLE;
                select_d = 1'b1;
                sck_d    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q    <= dswp_pkg::ST_IDLE;
            tx_shift_q <= 16'h0000;
            rx_shift_q <= 8'h00;
            rx_data_q  <= 8'h00;
            bits_q     <= 5'h00;
            select_q   <= 1'b1;
            dc_q       <= 1'b0;
            sck_q      <= 1'b0;
            mosi_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            tx_shift_q <= tx_shift_d;
            rx_shift_q <= rx_shift_d;
            rx_data_q  <= rx_data_d;
            bits_q     <= bits_d;
            select_q   <= select_d;
            dc_q       <= dc_d;
            sck_q      <= sck_d;
            mosi_q     <= mosi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software registers

    always_comb
    begin
        ctrl_d     = ctrl_q;
        overflow_d = overflow_q;
        rdata_d    = 32'h0000_0000;
        if (i_reg_write && reg_hit(i_reg_addr, dswp_pkg::REG_CONTROL))
        begin
            ctrl_d = i_reg_wdata[1:0];
        end
        // write one to clear; a fresh overflow in the same cycle wins
        if (i_reg_write && reg_hit(i_reg_addr, dswp_pkg::REG_STATUS)
            && i_reg_wdata[dswp_pkg::STAT_OVERFLOW_BIT])
        begin
            overflow_d = 1'b0;
        end
        if (push_valid && !fifo_ready)
        begin
            overflow_d = 1'b1;
        end
        if (i_reg_read)
        begin
            if (reg_hit(i_reg_addr, dswp_pkg::REG_CONTROL))
            begin
                rdata_d[1:0] = ctrl_q;
            end
            else if (reg_hit(i_reg_addr, dswp_pkg::REG_STATUS))
            begin
                rdata_d[dswp_pkg::STAT_BUSY_BIT]     = run || fifo_valid;
                rdata_d[dswp_pkg::STAT_FULL_BIT]     = !fifo_ready;
                rdata_d[dswp_pkg::STAT_EMPTY_BIT]    = !fifo_valid;
                rdata_d[dswp_pkg::STAT_OVERFLOW_BIT] = overflow_q;
                rdata_d[dswp_pkg::STAT_COUNT_LSB +: CW] = fifo_count;
            end
            else if (reg_hit(i_reg_addr, dswp_pkg::REG_RXDATA))
            begin
                rdata_d[7:0] = rx_data_q;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_q     <= dswp_pkg::CTRL_RESET_VALUE;
            overflow_q <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            overflow_q <= overflow_d;
            rdata_q    <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_reg_rdata          = rdata_q;
    assign o_display_select_low = select_q;
    assign o_cmd_data_select    = dc_q;
    assign o_serial_clock       = sck_q;
    assign o_serial_write_data  = mosi_q;
    assign o_backlight_enable   = ctrl_q[dswp_pkg::CTRL_BACKLIGHT_BIT];
    assign o_display_reset_n    = !ctrl_q[dswp_pkg::CTRL_RESET_BIT];

endmodule : dswp_host

`default_nettype wire

// ==== rtl/dswp_pkg.sv ====
// dswp_pkg: constants, register map and types for the display serial write port.
// assumes a single 100 MHz clock; every user of these names writes dswp_pkg::name.

package dswp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and link timing
    localparam int CLOCK_PERIOD_NS = 10;
    // half period of the serial clock; least time, so rounded up
    localparam int SCK_HALF_NS     = 40;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DIV_WIDTH       = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // software register map (byte addresses)
    localparam int ADDR_WIDTH = 8;
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_COMMAND = 8'h08;
    localparam logic [7:0] REG_PARAM   = 8'h0c;
    localparam logic [7:0] REG_PIXEL   = 8'h10;
    localparam logic [7:0] REG_RXDATA  = 8'h14;

    // control fields
    localparam int CTRL_BACKLIGHT_BIT = 0;
    localparam int CTRL_RESET_BIT     = 1;
    localparam logic [1:0] CTRL_RESET_VALUE = 2'h0;

    // status fields
    localparam int STAT_BUSY_BIT     = 0;
    localparam int STAT_FULL_BIT     = 1;
    localparam int STAT_EMPTY_BIT    = 2;
    localparam int STAT_OVERFLOW_BIT = 3;
    localparam int STAT_COUNT_LSB    = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // transfer sizes
    localparam int BYTE_BITS  = 8;
    localparam int PIXEL_BITS = 16;
    localparam int FIFO_DEPTH = 4;

    // one queued transfer: command/data level, length and payload
    typedef struct packed {
        logic        is_pixel;
        logic        is_data;
        logic [15:0] payload;
    } dswp_item_s;

    localparam int ITEM_WIDTH = $bits(dswp_item_s);

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_LEAD = 6'b000010,
        ST_HIGH = 6'b000100,
        ST_LOW  = 6'b001000,
        ST_TAIL = 6'b010000,
        ST_REST = 6'b100000
    } dswp_state_e;

endpackage : dswp_pkg
